/* File: core/adc_scan_sequencer_map.vh */
// register map, field positions, reset values and counts of the scan sequencer
// assumes inclusion by bare name from the sequencer core, the checker and the bench
`ifndef ADC_SCAN_SEQUENCER_MAP_VH
`define ADC_SCAN_SEQUENCER_MAP_VH

// register offsets (word index on the internal register port)
`define OFS_CONFIG0 4'h1
`define OFS_CONFIG2 4'h3
`define OFS_CONFIG3 4'h4
`define OFS_INPUT_SELECT 4'h6
`define OFS_SCAN 4'h7
`define OFS_TIMER 4'h8

// config0: converter mode field
`define ADC_MODE_LSB 0
`define ADC_MODE_MSB 1
// config2: programmed gain, auto-zero mux enable
`define GAIN_LSB 3
`define GAIN_MSB 5
`define AUTO_ZERO_MUX_ENABLE_BIT 2
// config3: conversion mode and output format
`define CONV_MODE_LSB 6
`define CONV_MODE_MSB 7
`define DATA_FORMAT_LSB 4
`define DATA_FORMAT_MSB 5
// scan register: enables and inter-conversion delay code
`define SCAN_EN_LSB 0
`define SCAN_EN_MSB 15
`define DLY_LSB 21
`define DLY_MSB 23

// reset values
`define RST_CONFIG0 8'h00
`define RST_ADC_MODE 2'h0
`define RST_GAIN 3'h1
`define RST_CONFIG2 8'h08
`define RST_CONFIG3 8'h00
`define RST_INPUT_SELECT 8'h01
`define RST_SCAN 24'h000000
`define RST_TIMER 24'h000000

// modes
`define MODE_SHUTDOWN 2'h0
`define MODE_STANDBY 2'h2
`define MODE_CONVERT 2'h3
`define FORMAT_WITH_ID 2'h3

// forced gain codes and internal channel mux codes
`define GAIN_THIRD 3'h0
`define GAIN_ONE 3'h1
`define MUX_OFFSET 8'h88
`define MUX_VCM 8'hF8
`define MUX_AVDD 8'h98
`define MUX_TEMP 8'hDE

// timing in modulator clock periods
`define CONV_PERIODS 16'h0100
`define SETUP_PERIODS 24'h000100
`define DLY_UNIT 10'h008

`endif

/* File: core/adc_scan_sequencer.v */
// scan sequencer of a multichannel delta-sigma converter: walks the enabled
// channels, drives mux, forced gain and power state, and buffers results.
// assumes an spi decoder on mclk drives the register port, the modulator clock
// arrives as a plain pin, and the converter core delivers data on mclk.
`include "adc_scan_sequencer_map.vh"

module adc_scan_sequencer #(
   parameter [15:0] CHAN_PRESENT = 16'hFFFF // enable bits that exist on this variant
) (
   input wire mclk,
   input wire rst_n,
   input wire reg_wr,
   input wire reg_rd,
   input wire [3:0] reg_addr,
   input wire [23:0] reg_wdata,
   output reg [23:0] reg_rdata,
   input wire dmclk,
   input wire [15:0] conv_data,
   output reg conv_start,
   output reg conv_one_shot,
   output reg [7:0] input_select_code,
   output reg [2:0] conv_gain,
   output reg temp_diode_enable,
   output reg offset_short,
   output reg [1:0] conv_power,
   output wire result_valid,
   input wire result_ready,
   output reg [19:0] result_register
);

   ////////////////////////////////////////////////////////////////////////////
   // state encodings
   localparam [4:0] ST_IDLE = 5'h01; // single-input or stopped
   localparam [4:0] ST_CONV = 5'h02; // converting one channel
   localparam [4:0] ST_DLY = 5'h04; // settling gap inside a sequence
   localparam [4:0] ST_TIMER = 5'h08; // gap between sequences
   localparam [4:0] ST_PUSH = 5'h10; // waiting for room in the buffer

   ////////////////////////////////////////////////////////////////////////////
   // registers seen by software
   reg [1:0] adc_mode; // converter-mode field as stored
   reg [7:0] config2; // gain and auto-zero
   reg [7:0] config3; // conversion mode and format
   reg [7:0] input_select; // single-input mux code
   reg [23:0] scan; // enables and delay code
   reg [23:0] timer; // inter-sequence delay
   reg [4:0] state; // sequencer state
   reg [3:0] chan; // channel being converted
   reg [23:0] count; // dmclk period counter
   reg [2:0] dmclk_sync; // two-stage sync plus edge history
   reg [19:0] buf_mem [0:1]; // two-entry result buffer
   reg buf_wp; // buffer write slot
   reg buf_rp; // buffer read slot
   reg [1:0] buf_cnt; // words held
   reg [19:0] push_word; // word waiting to enter the buffer

   wire [1:0] conv_mode_field = config3[`CONV_MODE_MSB:`CONV_MODE_LSB];
   wire [1:0] data_format = config3[`DATA_FORMAT_MSB:`DATA_FORMAT_LSB];
   wire [15:0] scan_en = scan[`SCAN_EN_MSB:`SCAN_EN_LSB];
   wire [2:0] dly_code = scan[`DLY_MSB:`DLY_LSB];
   wire scan_mode = |scan_en;
   wire dm_tick = dmclk_sync[1] & ~dmclk_sync[2]; // rising edge of modulator clock
   wire buf_full = buf_cnt[1];
   wire buf_in_ready = ~buf_full;
   wire sequencing = (state != ST_IDLE);
   wire mode_write = reg_wr & (reg_addr == `OFS_CONFIG0);
   wire [1:0] mode_wdata = reg_wdata[`ADC_MODE_MSB:`ADC_MODE_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // highest enabled channel strictly below a given index; found flag in bit 4
   function [4:0] next_below;
      input [15:0] en;
      input [4:0] from;
      integer i;
      begin
         next_below = 5'h00;
         for (i = 0; i < 16; i = i + 1) begin
            if (en[i] && (i < from)) begin
               next_below = {1'b1, i[3:0]}; // later hits are higher, so they win
            end
         end
      end
   endfunction

   // channel to mux code; internal ones fixed, the rest from the table
   function [7:0] chan_mux;
      input [3:0] c;
      begin
         case (c)
            4'hF: chan_mux = `MUX_OFFSET;
            4'hE: chan_mux = `MUX_VCM;
            4'hD: chan_mux = `MUX_AVDD;
            4'hC: chan_mux = `MUX_TEMP;
            4'hB: chan_mux = 8'h67;
            4'hA: chan_mux = 8'h45;
            4'h9: chan_mux = 8'h23;
            4'h8: chan_mux = 8'h01;
            default: chan_mux = {1'b0, c[2:0], 4'h8}; // single-ended inputs
         endcase
      end
   endfunction

   // inter-conversion delay in modulator periods, zero for code 0
   function [23:0] dly_periods;
      input [2:0] code;
      begin
         if (code == 3'h0) begin
            dly_periods = 24'h000000;
         end else begin
            dly_periods = {14'h0000, `DLY_UNIT << (code - 3'h1)};
         end
      end
   endfunction

   wire [4:0] first_chan = next_below(scan_en, 5'h10);
   wire [4:0] after_chan = next_below(scan_en, {1'b0, chan});
   wire [15:0] conv_len = config2[`AUTO_ZERO_MUX_ENABLE_BIT] ? (`CONV_PERIODS << 1) : `CONV_PERIODS;

   ////////////////////////////////////////////////////////////////////////////
   // modulator clock sampling; only stage 1 and 2 feed the edge detector
   always @(posedge mclk) begin
      if (!rst_n) begin
         dmclk_sync <= 3'h0;
      end else begin
         dmclk_sync <= {dmclk_sync[1:0], dmclk};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes; sequencer ends also rewrite the converter mode
   always @(posedge mclk) begin
      if (!rst_n) begin
         adc_mode <= `RST_ADC_MODE;
         config2 <= `RST_CONFIG2;
         config3 <= `RST_CONFIG3;
         input_select <= `RST_INPUT_SELECT;
         scan <= `RST_SCAN;
         timer <= `RST_TIMER;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `OFS_CONFIG0: adc_mode <= mode_wdata; // only a pass end rewrites it
               `OFS_CONFIG2: config2 <= reg_wdata[7:0];
               // no restart here: a running conversion keeps going
               `OFS_CONFIG3: config3 <= reg_wdata[7:0];
               `OFS_INPUT_SELECT: input_select <= reg_wdata[7:0];
               // absent channels stay zero whatever is written
               `OFS_SCAN: scan <= {reg_wdata[23:16], reg_wdata[15:0] & CHAN_PRESENT};
               `OFS_TIMER: timer <= reg_wdata;
               default: ; // unmapped writes ignored
            endcase
         end
         // one pass finished: fall back to the mode the conversion mode names
         if (!mode_write && state == ST_PUSH && buf_in_ready && !after_chan[4]
               && conv_mode_field != `MODE_CONVERT) begin
            adc_mode <= conv_mode_field[1] ? `MODE_STANDBY : `MODE_SHUTDOWN;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads, registered; mode reads 11 all through a scan run
   always @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 24'h000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_CONFIG0: reg_rdata <= {22'h000000,
                                        sequencing ? `MODE_CONVERT : adc_mode};
            `OFS_CONFIG2: reg_rdata <= {16'h0000, config2};
            `OFS_CONFIG3: reg_rdata <= {16'h0000, config3};
            `OFS_INPUT_SELECT: reg_rdata <= {16'h0000, input_select};
            `OFS_SCAN: reg_rdata <= scan;
            `OFS_TIMER: reg_rdata <= timer;
            default: reg_rdata <= 24'h000000; // unmapped reads as zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer; counts modulator periods, stalls when the buffer is full
   always @(posedge mclk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         chan <= 4'h0;
         count <= 24'h000000;
         conv_start <= 1'b0;
         conv_power <= `MODE_SHUTDOWN;
         push_word <= 20'h00000;
      end else begin
         conv_start <= 1'b0;
         if (mode_write && mode_wdata != `MODE_CONVERT) begin
            // any other mode written aborts the run
            state <= ST_IDLE;
            conv_power <= mode_wdata;
         end else if (mode_write && scan_mode) begin
            // start, or restart of the whole cycle, on a write of 11
            state <= ST_CONV;
            chan <= first_chan[3:0];
            count <= {8'h00, conv_len};
            conv_start <= 1'b1;
            conv_power <= `MODE_CONVERT;
         end else begin
            case (state)
               ST_IDLE: begin
                  // single-input mode follows the stored mode
                  conv_power <= adc_mode;
               end
               ST_CONV: begin
                  if (dm_tick) begin
                     if (count == 24'h000001) begin
                        state <= ST_PUSH;
                        // id in the top nibble only in format 11
                        push_word <= {(data_format == `FORMAT_WITH_ID) ? chan : 4'h0,
                                      conv_data};
                     end
                     count <= count - 24'h000001;
                  end
               end
               ST_PUSH: begin
                  if (buf_in_ready) begin
                     if (after_chan[4]) begin
                        // mux moves on at once; the gap lets it settle
                        chan <= after_chan[3:0];
                        count <= dly_periods(dly_code);
                        state <= ST_DLY;
                        conv_power <= `MODE_STANDBY;
                     end else if (conv_mode_field == `MODE_CONVERT) begin
                        // lowest channel done: wait the timer, then go again
                        chan <= first_chan[3:0];
                        count <= timer;
                        state <= ST_TIMER;
                        conv_power <= (timer > `SETUP_PERIODS) ? `MODE_SHUTDOWN
                                                               : `MODE_STANDBY;
                     end else begin
                        state <= ST_IDLE;
                        conv_power <= conv_mode_field[1] ? `MODE_STANDBY : `MODE_SHUTDOWN;
                     end
                  end
               end
               ST_DLY: begin
                  if (count == 24'h000000) begin
                     state <= ST_CONV;
                     count <= {8'h00, conv_len};
                     conv_start <= 1'b1;
                     conv_power <= `MODE_CONVERT;
                  end else if (dm_tick) begin
                     count <= count - 24'h000001;
                  end
               end
               ST_TIMER: begin
                  if (!scan_mode) begin
                     state <= ST_IDLE; // enables cleared: back to single input
                  end else if (count == 24'h000000) begin
                     state <= ST_CONV;
                     count <= {8'h00, conv_len};
                     conv_start <= 1'b1;
                     conv_power <= `MODE_CONVERT;
                  end else if (dm_tick) begin
                     if (count == `SETUP_PERIODS && conv_power == `MODE_SHUTDOWN) begin
                        // power back up so the converter is settled at zero
                        conv_power <= `MODE_STANDBY;
                     end
                     count <= count - 24'h000001;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-conversion analog settings; registers themselves never touched
   always @(posedge mclk) begin
      if (!rst_n) begin
         input_select_code <= `RST_INPUT_SELECT;
         conv_gain <= `RST_GAIN;
         temp_diode_enable <= 1'b0;
         offset_short <= 1'b0;
         conv_one_shot <= 1'b0;
      end else if (scan_mode) begin
         // stored input select plays no part here
         input_select_code <= chan_mux(chan);
         conv_one_shot <= 1'b1;
         temp_diode_enable <= (chan == 4'hC);
         offset_short <= (chan == 4'hF);
         case (chan)
            4'hD: conv_gain <= `GAIN_THIRD;
            4'hE, 4'hC: conv_gain <= `GAIN_ONE;
            default: conv_gain <= config2[`GAIN_MSB:`GAIN_LSB];
         endcase
      end else begin
         input_select_code <= input_select;
         conv_gain <= config2[`GAIN_MSB:`GAIN_LSB];
         temp_diode_enable <= 1'b0;
         offset_short <= 1'b0;
         conv_one_shot <= (conv_mode_field != `MODE_CONVERT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-entry result buffer; a full buffer holds the sequencer in push
   // so a slow reader delays the scan rather than losing words
   wire buf_push = (state == ST_PUSH) & buf_in_ready & ~mode_write;
   wire buf_pop = result_valid & result_ready;
   assign result_valid = (buf_cnt != 2'h0); // data-ready level

   always @(posedge mclk) begin
      if (!rst_n) begin
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         buf_cnt <= 2'h0;
         buf_mem[0] <= 20'h00000;
         buf_mem[1] <= 20'h00000;
      end else begin
         if (buf_push) begin
            buf_mem[buf_wp] <= push_word;
            buf_wp <= ~buf_wp;
         end
         if (buf_pop) begin
            buf_rp <= ~buf_rp;
         end
         buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // result word shown to the reader comes from a flip-flop
   always @(posedge mclk) begin
      if (!rst_n) begin
         result_register <= 20'h00000;
      end else if (buf_cnt == 2'h0 && buf_push) begin
         result_register <= push_word;
      end else if (buf_pop) begin
         result_register <= (buf_cnt == 2'h2) ? buf_mem[~buf_rp] : push_word;
      end
   end

endmodule // adc_scan_sequencer

/* File: bench/adc_scan_sequencer_checker.sv */
// port-level checks of the scan sequencer
// assumes eight mclk periods per modulator clock period, as in the bench
`include "adc_scan_sequencer_map.vh"
module adc_scan_checker #(
   parameter int MIN_CONV_MCLK = 2040 // shortest start-to-start spacing
) (
   input wire mclk,
   input wire rst_n,
   input wire reg_wr,
   input wire [3:0] reg_addr,
   input wire [23:0] reg_wdata,
   input wire conv_start,
   input wire conv_one_shot,
   input wire [7:0] input_select_code,
   input wire [2:0] conv_gain,
   input wire temp_diode_enable,
   input wire offset_short,
   input wire [1:0] conv_power,
   input wire result_valid,
   input wire result_ready,
   input wire [19:0] result_register
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [12:0] gap; // mclk periods since last start, saturating
   ////////////////////////////////////////////////////////////////////////
   // a restart write legally cuts a conversion short, so it voids the count
   always @(posedge mclk) begin
      if (!rst_n || (reg_wr && reg_addr == `OFS_CONFIG0 && reg_wdata[1:0] == 2'h3))
         gap <= 13'h1FFF;
      else if (conv_start)
         gap <= 13'h0000;
      else if (gap != 13'h1FFF)
         gap <= gap + 13'h0001;
   end
   ////////////////////////////////////////////////////////////////////////
   a_start_one_shot: assert property (conv_start |-> conv_one_shot)
      else $error("conversion started outside one-shot scan");
   a_conv_length: assert property (conv_start |-> gap >= MIN_CONV_MCLK)
      else $error("conversion ended too early");
   a_start_powered: assert property (conv_start |=> (conv_power == `MODE_CONVERT)[*8])
      else $error("converter not powered after start");
   a_temp_forced: assert property (temp_diode_enable |-> input_select_code == `MUX_TEMP
      && conv_gain == `GAIN_ONE)
      else $error("temperature channel settings wrong");
   a_offset_short: assert property (offset_short |-> input_select_code == `MUX_OFFSET)
      else $error("offset short on wrong channel");
   a_supply_gain: assert property (conv_start ##2 input_select_code == `MUX_AVDD
      |-> conv_gain == `GAIN_THIRD)
      else $error("supply channel gain not forced");
   a_vcm_gain: assert property (conv_start ##2 input_select_code == `MUX_VCM
      |-> conv_gain == `GAIN_ONE)
      else $error("common-mode channel gain not forced");
   a_result_hold: assert property (result_valid && !result_ready
      |=> result_valid && $stable(result_register))
      else $error("unread result lost or changed");
   a_mux_idle: assert property (!conv_one_shot |-> !conv_start && !offset_short
      && !temp_diode_enable)
      else $error("scan activity in single-input mode");
endmodule // adc_scan_checker

bind adc_scan_sequencer adc_scan_checker adc_scan_checker_i (.mclk(mclk), .rst_n(rst_n),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .conv_start(conv_start),
   .conv_one_shot(conv_one_shot), .input_select_code(input_select_code),
   .conv_gain(conv_gain), .temp_diode_enable(temp_diode_enable),
   .offset_short(offset_short), .conv_power(conv_power), .result_valid(result_valid),
   .result_ready(result_ready), .result_register(result_register));

/* File: bench/result_reader_model.sv */
// host-side reader: pops each result word and keeps them in arrival order
// assumes the result handshake runs on mclk; stall holds ready low
module result_reader_model (
   input wire mclk,
   input wire rst_n,
   input wire stall,
   input wire result_valid,
   input wire [19:0] result_register,
   output logic result_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [19:0] words [$]; // popped words, oldest first
   initial result_ready = 1'b0;
   // ready moves off the sampling edge, so a pop edge is never ambiguous
   always @(negedge mclk)
      result_ready <= rst_n && !stall;
   // a word counts as read at the edge where valid and ready meet
   always @(posedge mclk)
      if (rst_n && result_valid && result_ready)
         words.push_back(result_register);
endmodule // result_reader_model

/* File: bench/adc_scan_sequencer_tb_top.sv */
// self-checking bench of the scan sequencer: register tasks and scan cycles
// assumes the map header on the include path and the bound checker
`include "adc_scan_sequencer_map.vh"
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
   $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module adc_scan_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, reg_wr, reg_rd, dmclk, stall;
   logic [3:0] reg_addr;
   logic [23:0] reg_wdata;
   logic [15:0] nconv = 16'h0000; // conversions started so far
   logic [15:0] starts_used = 16'h0000; // starts already claimed by run_scan
   wire [15:0] conv_data = 16'h1000 + nconv; // stamps each conversion
   wire [23:0] reg_rdata;
   wire conv_start, conv_one_shot, temp_diode_enable, offset_short, result_valid, result_ready;
   wire [7:0] input_select_code;
   wire [2:0] conv_gain;
   wire [1:0] conv_power;
   wire [19:0] result_register;
   int num_errors = 0;
   int tests_run = 0;
   int n;
   logic [19:0] expq [$]; // words the reader should have seen
   logic [7:0] mux_tab [16] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h58, 8'h68, 8'h78,
      8'h01, 8'h23, 8'h45, 8'h67, 8'hDE, 8'h98, 8'hF8, 8'h88};
   // reduced variant: enables 11:10 and 7:4 absent
   adc_scan_sequencer #(.CHAN_PRESENT(16'hF30F)) adc_scan_sequencer_i (.mclk(mclk),
      .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dmclk(dmclk), .conv_data(conv_data),
      .conv_start(conv_start), .conv_one_shot(conv_one_shot),
      .input_select_code(input_select_code), .conv_gain(conv_gain),
      .temp_diode_enable(temp_diode_enable), .offset_short(offset_short),
      .conv_power(conv_power), .result_valid(result_valid), .result_ready(result_ready),
      .result_register(result_register));
   result_reader_model result_reader_model_i (.mclk(mclk), .rst_n(rst_n), .stall(stall),
      .result_valid(result_valid), .result_register(result_register),
      .result_ready(result_ready));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // modulator clock, phase unrelated to mclk
   initial begin
      dmclk = 1'b0;
      #7;
      forever #80 dmclk = ~dmclk;
   end
   always @(negedge mclk)
      if (conv_start === 1'b1)
         nconv <= nconv + 16'h0001;
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [23:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic reg_check(input logic [3:0] a, input logic [23:0] exp, input string what);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      @(negedge mclk);
      `CHK(what, exp, reg_rdata)
   endtask
   // bounded waits, sampled at falling edges
   task automatic wait_pw(input logic [1:0] want, output int k);
      k = 0;
      while (conv_power !== want && k < 9000) begin
         @(negedge mclk);
         k++;
      end
      if (k >= 9000) `CHK("power wait", want, conv_power)
   endtask
   task automatic wait_start();
      int k;
      k = 0;
      // nconv counts every start, so a start already past is never missed
      while (nconv <= starts_used && k < 9000) begin
         @(negedge mclk);
         k++;
      end
      if (k >= 9000) `CHK("start wait", starts_used + 16'h0001, nconv)
      starts_used = starts_used + 16'h0001;
   endtask
   // one scan cycle; hold_at releases a stalled reader, dly checks the gap
   task automatic run_scan(input int chs[$], input logic id, input int hold_at,
      input logic dly);
      int k;
      logic [2:0] g;
      foreach (chs[i]) begin
         if (i > 0 && dly) begin
            wait_pw(`MODE_STANDBY, k);
            `CHK("gap power", `MODE_STANDBY, conv_power)
         end
         wait_start();
         @(negedge mclk);
         @(negedge mclk);
         g = chs[i] == 13 ? `GAIN_THIRD : (chs[i] == 12 || chs[i] == 14) ? `GAIN_ONE : 3'h5;
         `CHK("mux code", mux_tab[chs[i]], input_select_code)
         `CHK("gain", g, conv_gain)
         `CHK("temp diodes", chs[i] == 12, temp_diode_enable)
         `CHK("offset short", chs[i] == 15, offset_short)
         `CHK("one shot", 1'b1, conv_one_shot)
         expq.push_back({id ? chs[i][3:0] : 4'h0, 16'h1000 + nconv});
         if (i == hold_at) begin
            repeat (3000) @(negedge mclk);
            `CHK("ready held", 1'b1, result_valid)
            stall = 1'b0;
         end
      end
   endtask
   task automatic check_words();
      repeat (4) @(negedge mclk);
      `CHK("word count", expq.size(), result_reader_model_i.words.size())
      foreach (expq[i]) `CHK("word", expq[i], result_reader_model_i.words[i])
      expq.delete();
      result_reader_model_i.words.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      num_errors++;
      stop_test();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, stall, reg_addr, reg_wdata} = '0;
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      `CHK("reset power", `MODE_SHUTDOWN, conv_power)
      `CHK("reset mux", 8'h01, input_select_code)
      reg_check(`OFS_INPUT_SELECT, 24'h000001, "select reset");
      reg_check(4'hF, 24'h000000, "unmapped read");
      reg_write(`OFS_INPUT_SELECT, 24'h000023);
      reg_write(`OFS_SCAN, 24'h20FFFF);
      reg_check(`OFS_SCAN, 24'h20F30F, "absent enables");
      // one pass with ids, reader stalled over the first two words
      reg_write(`OFS_CONFIG2, 24'h000028);
      reg_write(`OFS_CONFIG3, 24'h000030);
      reg_write(`OFS_SCAN, 24'h00F101);
      `CHK("no start before mode", 18'h00000, {nconv, conv_power})
      stall = 1'b1;
      reg_write(`OFS_CONFIG0, 24'h000003);
      run_scan('{15, 14, 13, 12, 8, 0}, 1'b1, 1, 1'b0);
      reg_check(`OFS_CONFIG0, 24'h000003, "mode held");
      wait_pw(`MODE_SHUTDOWN, n);
      reg_check(`OFS_CONFIG0, 24'h000000, "mode after pass");
      check_words();
      reg_check(`OFS_CONFIG2, 24'h000028, "gain kept");
      reg_write(`OFS_SCAN, 24'h000000);
      repeat (2) @(negedge mclk);
      `CHK("single input again", 8'h23, input_select_code)
      // repeating cycles, timer above setup, delay code 1
      reg_write(`OFS_TIMER, 24'h00012C);
      reg_write(`OFS_CONFIG3, 24'h0000C0);
      reg_write(`OFS_SCAN, 24'h200202);
      reg_write(`OFS_CONFIG0, 24'h000003);
      run_scan('{9, 1}, 1'b0, -1, 1'b1);
      wait_pw(`MODE_SHUTDOWN, n);
      reg_check(`OFS_CONFIG0, 24'h000003, "mode between");
      wait_pw(`MODE_STANDBY, n);
      `CHK("startup at 256", 1'b1, n > 320 && n < 390)
      run_scan('{9}, 1'b0, -1, 1'b0);
      reg_write(`OFS_CONFIG3, 24'h000080);
      run_scan('{1}, 1'b0, -1, 1'b0);
      wait_pw(`MODE_STANDBY, n);
      reg_check(`OFS_CONFIG0, 24'h000002, "mode after standby pass");
      check_words();
      // auto-zero doubles the conversion
      reg_write(`OFS_CONFIG3, 24'h000000);
      reg_write(`OFS_CONFIG2, 24'h00002C);
      reg_write(`OFS_SCAN, 24'h000001);
      reg_write(`OFS_CONFIG0, 24'h000003);
      run_scan('{0}, 1'b0, -1, 1'b0);
      wait_pw(`MODE_SHUTDOWN, n);
      `CHK("auto-zero length", 1'b1, n > 4000 && n < 4200)
      check_words();
      stop_test();
   end
endmodule // adc_scan_sequencer_tb_top
